//--- hdl/cmc_pkg.sv
// cmc_pkg: constants, types and helpers of the clock and mode controller
// assumes a 100 MHz fabric clock from which the internal oscillator is modelled
package cmc_pkg;

	localparam int unsigned SYS_CLK_HZ      = 100_000_000;
	localparam int unsigned OSC_32K_HZ      = 32_000;
	localparam int unsigned OSC_64K_HZ      = 64_000;
	localparam int unsigned OSC_128K_HZ     = 128_000;
	// half-period counts; a longest time rounds down
	localparam int unsigned OSC_32K_HALF    = SYS_CLK_HZ / (2 * OSC_32K_HZ);
	localparam int unsigned OSC_64K_HALF    = SYS_CLK_HZ / (2 * OSC_64K_HZ);
	localparam int unsigned OSC_128K_HALF   = SYS_CLK_HZ / (2 * OSC_128K_HZ);
	localparam int unsigned OSC_CNT_W       = 11;

	// configuration option codes for the oscillator frequency
	localparam logic [1:0] OSC_SEL_32K      = 2'h0;
	localparam logic [1:0] OSC_SEL_64K      = 2'h1;
	localparam logic [1:0] OSC_SEL_128K     = 2'h2;

	// register map (byte addresses)
	localparam logic [3:0] ADDR_CLK_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_STATUS      = 4'h4;
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_DECERR      = 2'h3;

	// system_clock_control layout
	localparam int unsigned DIV_SEL_MSB     = 7;
	localparam int unsigned DIV_SEL_LSB     = 5;
	localparam int unsigned IDLE_KEEP_BIT   = 1;
	localparam logic [7:0] CLK_CTRL_RESET   = 8'h00;
	localparam logic [7:0] CLK_CTRL_MASK    = 8'hE2;

	localparam int unsigned DIV_CNT_W       = 6;

	typedef enum logic [1:0] {
		CMC_NORMAL,
		CMC_IDLE,
		CMC_SLEEP
	} cmc_mode_t;

	// half-ticks of the high-speed clock per system clock half period, minus one
	function automatic logic [DIV_CNT_W-1:0] cmc_div_limit(input logic [2:0] sel);
		logic [DIV_CNT_W:0] half;
		half = 7'h01;
		if (sel != 3'h0 && sel != 3'h7) begin
			half = 7'h01 << sel;
		end
		return DIV_CNT_W'(half - 7'h01);
	endfunction

endpackage

//--- hdl/cmc_clk_if.sv
// cmc_clk_if: carries the high-speed clock ticks and divider controls
// assumes both ends run on the single fabric clock
`timescale 1ns/1ps
`default_nettype none
interface cmc_clk_if;
	logic       hs_tick;
	logic       hs_level;
	logic [2:0] div_sel;
	logic       sys_clk;
	logic       sys_edge;

	modport ctl (output hs_tick, output hs_level, output div_sel, input sys_clk, input sys_edge);
	modport div (input hs_tick, input hs_level, input div_sel, output sys_clk, output sys_edge);
endinterface
`default_nettype wire

//--- hdl/cmc_divider.sv
// cmc_divider: derives the system clock from high-speed clock half-ticks
// assumes hs_tick pulses once per high-speed half period, only while it runs
`timescale 1ns/1ps
`default_nettype none
module cmc_divider (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	cmc_clk_if.div    link
);
	import cmc_pkg::*;

	logic [DIV_CNT_W-1:0] cnt_reg;
	logic [DIV_CNT_W-1:0] limit_reg;
	logic                 sys_reg;
	logic                 edge_reg;

	assign link.sys_clk  = sys_reg;
	assign link.sys_edge = edge_reg;

	// a new ratio is loaded only at a falling edge, so every half period is whole
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg   <= '0;
			limit_reg <= '0;
			sys_reg   <= 1'b0;
			edge_reg  <= 1'b0;
		end else begin
			edge_reg <= 1'b0;
			if (link.hs_tick) begin
				if (cnt_reg == limit_reg) begin
					cnt_reg  <= '0;
					sys_reg  <= ~sys_reg;
					edge_reg <= 1'b1;
					if (sys_reg) begin
						limit_reg <= cmc_div_limit(link.div_sel);
					end
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end

	AST_DIV_EDGE_ON_TICK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		edge_reg |-> $past(link.hs_tick))
		else $error("system clock moved without a high-speed tick");

	AST_DIV_NO_RUNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(sys_reg) |-> $past(cnt_reg) == $past(limit_reg))
		else $error("system clock rose before its half period ended");

endmodule
`default_nettype wire

//--- hdl/cmc_top.sv
// cmc_top: clock and operating-mode controller with an AXI4-Lite register slave
// assumes halt, interrupt and watchdog inputs come from logic on SYS_CLK_I
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - oscillator runs at 32, 64 or 128 kHz, fixed by a build parameter.
// - one system clock feeds both the core and the peripherals.
// - system clock is the high-speed clock or its division, set by select field.
// - in NORMAL the divider ratio spans 1 to 64.
// - substitute clock is always 32 kHz, taken from the oscillator.
// - exactly three modes: NORMAL runs the core, IDLE and SLEEP stop it.
// - halt with keep bit 0 enters SLEEP; system and high-speed clocks stop.
// - entering SLEEP turns off the voltage detector and LCD automatically.
// - in SLEEP substitute clock runs only while the watchdog is enabled.
// - halt with keep bit 1 enters IDLE; all clocks but the core clock stay on.
// - in IDLE the core clock is gated; the oscillator keeps running.
// - control register is 8 bits: select at 7..5, keep bit at 1.
// - select codes 000 and 111 undivided, 001..110 divide by 2..64.
// - bits 4..2 and 0 of the control register read zero.
// - entering a halt mode sets power-down, clears time-out flag and watchdog count.
// - wake on port A falling edge, reset, interrupt or watchdog overflow.
module cmc_top #(
	parameter logic [1:0] OSC_SEL = cmc_pkg::OSC_SEL_32K
) (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic [3:0]  AXI_AWADDR_I,
	input  wire logic        AXI_AWVALID_I,
	output logic             AXI_AWREADY_O,
	input  wire logic [31:0] AXI_WDATA_I,
	input  wire logic [3:0]  AXI_WSTRB_I,
	input  wire logic        AXI_WVALID_I,
	output logic             AXI_WREADY_O,
	output logic [1:0]       AXI_BRESP_O,
	output logic             AXI_BVALID_O,
	input  wire logic        AXI_BREADY_I,
	input  wire logic [3:0]  AXI_ARADDR_I,
	input  wire logic        AXI_ARVALID_I,
	output logic             AXI_ARREADY_O,
	output logic [31:0]      AXI_RDATA_O,
	output logic [1:0]       AXI_RRESP_O,
	output logic             AXI_RVALID_O,
	input  wire logic        AXI_RREADY_I,
	input  wire logic        HALT_I,
	input  wire logic        PORTA_WAKE_I,
	input  wire logic        INT_REQ_I,
	input  wire logic        WDT_OVF_I,
	input  wire logic        WDT_EN_I,
	output logic             HS_CLK_O,
	output logic             SYS_CLK_O,
	output logic             CPU_CLK_O,
	output logic             SUB_CLK_O,
	output cmc_pkg::cmc_mode_t MODE_O,
	output logic             LVD_LCD_OFF_O,
	output logic             PDF_SET_O,
	output logic             TO_CLR_O,
	output logic             WDT_CLR_O
);
	import cmc_pkg::*;

	localparam logic [OSC_CNT_W-1:0] OSC_HALF =
		(OSC_SEL == OSC_SEL_128K) ? OSC_CNT_W'(OSC_128K_HALF - 1) :
		(OSC_SEL == OSC_SEL_64K)  ? OSC_CNT_W'(OSC_64K_HALF - 1)  :
		                            OSC_CNT_W'(OSC_32K_HALF - 1);
	// oscillator half-ticks per substitute clock half period, minus one
	localparam logic [1:0] SUB_LIMIT =
		(OSC_SEL == OSC_SEL_128K) ? 2'h3 : (OSC_SEL == OSC_SEL_64K) ? 2'h1 : 2'h0;

	cmc_clk_if clk_link ();

	cmc_mode_t             mode_reg;
	cmc_mode_t             mode_next;
	logic [7:0]            ctrl_reg;
	logic [OSC_CNT_W-1:0]  osc_cnt_reg;
	logic                  osc_tick;
	logic                  hs_reg;
	logic [1:0]            sub_cnt_reg;
	logic                  sub_reg;
	logic                  osc_on;
	logic                  pa_meta_reg;
	logic                  pa_sync_reg;
	logic                  pa_prev_reg;
	logic                  wake;
	logic                  cpu_reg;
	logic                  sys_out_reg;
	logic                  lvd_off_reg;
	logic                  pdf_reg;
	logic                  halt_entry;

	logic                  aw_got_reg;
	logic                  w_got_reg;
	logic [3:0]            aw_addr_reg;
	logic [7:0]            w_data_reg;
	logic                  w_strb_reg;
	logic                  bvalid_reg;
	logic [1:0]            bresp_reg;
	logic                  rvalid_reg;
	logic [31:0]           rdata_reg;
	logic [1:0]            rresp_reg;
	logic                  aw_rdy_reg;
	logic                  w_rdy_reg;
	logic                  ar_rdy_reg;

	// oscillator keeps running in SLEEP only to feed the watchdog clock
	assign osc_on = (mode_reg != CMC_SLEEP) || WDT_EN_I;
	assign osc_tick = osc_on && (osc_cnt_reg == OSC_HALF);

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			osc_cnt_reg <= '0;
		end else if (osc_tick) begin
			osc_cnt_reg <= '0;
		end else if (osc_on) begin
			osc_cnt_reg <= osc_cnt_reg + 1'b1;
		end
	end

	// high-speed clock follows the oscillator, and stops in SLEEP
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			hs_reg <= 1'b0;
		end else if (osc_tick && mode_reg != CMC_SLEEP) begin
			hs_reg <= ~hs_reg;
		end
	end

	// substitute clock divides the oscillator down to a fixed 32 kHz
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sub_cnt_reg <= '0;
			sub_reg     <= 1'b0;
		end else if (osc_tick) begin
			if (sub_cnt_reg == SUB_LIMIT) begin
				sub_cnt_reg <= '0;
				sub_reg     <= ~sub_reg;
			end else begin
				sub_cnt_reg <= sub_cnt_reg + 1'b1;
			end
		end
	end

	assign clk_link.hs_tick  = osc_tick && (mode_reg != CMC_SLEEP);
	assign clk_link.hs_level = hs_reg;
	assign clk_link.div_sel  = ctrl_reg[DIV_SEL_MSB:DIV_SEL_LSB];

	cmc_divider u_div (
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RESETN_I),
		.link    (clk_link.div)
	);

	// port A pin is asynchronous; only the second stage feeds the edge detector
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pa_meta_reg <= 1'b1;
			pa_sync_reg <= 1'b1;
			pa_prev_reg <= 1'b1;
		end else begin
			pa_meta_reg <= PORTA_WAKE_I;
			pa_sync_reg <= pa_meta_reg;
			pa_prev_reg <= pa_sync_reg;
		end
	end

	assign wake = (pa_prev_reg && !pa_sync_reg) || INT_REQ_I || WDT_OVF_I;

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			CMC_NORMAL: begin
				if (HALT_I) begin
					mode_next = ctrl_reg[IDLE_KEEP_BIT] ? CMC_IDLE : CMC_SLEEP;
				end
			end
			CMC_IDLE, CMC_SLEEP: begin
				if (wake) begin
					mode_next = CMC_NORMAL;
				end
			end
			default: mode_next = CMC_NORMAL;
		endcase
	end

	assign halt_entry = (mode_reg == CMC_NORMAL) && (mode_next != CMC_NORMAL);

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mode_reg <= CMC_NORMAL;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// halt-entry pulses for the status and watchdog logic outside, and the sleep level that turns off LVD and LCD
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pdf_reg     <= 1'b0;
			lvd_off_reg <= 1'b0;
		end else begin
			pdf_reg     <= halt_entry;
			lvd_off_reg <= (mode_next == CMC_SLEEP);
		end
	end

	// registered clock outputs; core clock gated outside NORMAL
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cpu_reg     <= 1'b0;
			sys_out_reg <= 1'b0;
		end else begin
			sys_out_reg <= clk_link.sys_clk;
			cpu_reg     <= clk_link.sys_clk && (mode_reg == CMC_NORMAL);
		end
	end

	assign HS_CLK_O      = hs_reg;
	assign SUB_CLK_O     = sub_reg;
	assign SYS_CLK_O     = sys_out_reg;
	assign CPU_CLK_O     = cpu_reg;
	assign MODE_O        = mode_reg;
	assign LVD_LCD_OFF_O = lvd_off_reg;
	assign PDF_SET_O     = pdf_reg;
	assign TO_CLR_O      = pdf_reg;
	assign WDT_CLR_O     = pdf_reg;

	// write side: address and data are taken in either order
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			aw_got_reg  <= 1'b0;
			aw_addr_reg <= '0;
			aw_rdy_reg  <= 1'b1;
		end else if (AXI_AWVALID_I && !aw_got_reg && !bvalid_reg) begin
			aw_got_reg  <= 1'b1;
			aw_addr_reg <= AXI_AWADDR_I;
			aw_rdy_reg  <= 1'b0;
		end else if (bvalid_reg && AXI_BREADY_I) begin
			aw_got_reg  <= 1'b0;
			aw_rdy_reg  <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			w_got_reg  <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= 1'b0;
			w_rdy_reg  <= 1'b1;
		end else if (AXI_WVALID_I && !w_got_reg && !bvalid_reg) begin
			w_got_reg  <= 1'b1;
			w_data_reg <= AXI_WDATA_I[7:0];
			w_strb_reg <= AXI_WSTRB_I[0];
			w_rdy_reg  <= 1'b0;
		end else if (bvalid_reg && AXI_BREADY_I) begin
			w_got_reg  <= 1'b0;
			w_rdy_reg  <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (aw_got_reg && w_got_reg && !bvalid_reg) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= (aw_addr_reg == ADDR_CLK_CTRL || aw_addr_reg == ADDR_STATUS) ? RESP_OKAY : RESP_DECERR;
		end else if (bvalid_reg && AXI_BREADY_I) begin
			bvalid_reg <= 1'b0;
		end
	end

	// the select field is held through a halt and reused on wake
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ctrl_reg <= CLK_CTRL_RESET;
		end else if (aw_got_reg && w_got_reg && !bvalid_reg && w_strb_reg && aw_addr_reg == ADDR_CLK_CTRL) begin
			ctrl_reg <= w_data_reg & CLK_CTRL_MASK;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
			ar_rdy_reg <= 1'b1;
		end else if (AXI_ARVALID_I && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			ar_rdy_reg <= 1'b0;
			rresp_reg  <= RESP_OKAY;
			case (AXI_ARADDR_I)
				ADDR_CLK_CTRL: rdata_reg <= {24'h00_0000, ctrl_reg};
				ADDR_STATUS:   rdata_reg <= {28'h000_0000, osc_on, 1'b0, mode_reg};
				default: begin
					rdata_reg <= '0;
					rresp_reg <= RESP_DECERR;
				end
			endcase
		end else if (rvalid_reg && AXI_RREADY_I) begin
			rvalid_reg <= 1'b0;
			ar_rdy_reg <= 1'b1;
		end
	end

	// readies mirror the holding flags in flops of their own, so no port leaves through a gate
	assign AXI_AWREADY_O = aw_rdy_reg;
	assign AXI_WREADY_O  = w_rdy_reg;
	assign AXI_BVALID_O  = bvalid_reg;
	assign AXI_BRESP_O   = bresp_reg;
	assign AXI_ARREADY_O = ar_rdy_reg;
	assign AXI_RVALID_O  = rvalid_reg;
	assign AXI_RDATA_O   = rdata_reg;
	assign AXI_RRESP_O   = rresp_reg;

	AST_HALT_SLEEP: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(mode_reg == CMC_NORMAL && HALT_I && !ctrl_reg[IDLE_KEEP_BIT]) |=> mode_reg == CMC_SLEEP)
		else $error("halt with keep bit clear did not enter sleep");

	AST_HALT_IDLE: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(mode_reg == CMC_NORMAL && HALT_I && ctrl_reg[IDLE_KEEP_BIT]) |=> mode_reg == CMC_IDLE)
		else $error("halt with keep bit set did not enter idle");

	AST_SLEEP_HS_STILL: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(mode_reg == CMC_SLEEP && $past(mode_reg) == CMC_SLEEP) |-> $stable(hs_reg))
		else $error("high-speed clock moved in sleep");

	AST_SLEEP_SUB_STOP: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(mode_reg == CMC_SLEEP && !WDT_EN_I) |=> $stable(sub_reg))
		else $error("substitute clock ran in sleep with watchdog off");

	AST_LVD_OFF: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(mode_reg == CMC_SLEEP) |-> LVD_LCD_OFF_O)
		else $error("detector and LCD not disabled in sleep");

	AST_ENTRY_FLAGS: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		halt_entry |=> (PDF_SET_O && TO_CLR_O && WDT_CLR_O) ##1 !PDF_SET_O)
		else $error("halt entry flags not a single pulse");

	AST_WAKE: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(mode_reg != CMC_NORMAL && (INT_REQ_I || WDT_OVF_I)) |=> mode_reg == CMC_NORMAL)
		else $error("wake source did not restore normal mode");

	AST_CPU_GATED: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(mode_reg != CMC_NORMAL) |=> !CPU_CLK_O)
		else $error("core clock ran while halted");

	AST_RSVD_ZERO: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(ctrl_reg & ~CLK_CTRL_MASK) == 8'h00)
		else $error("unimplemented control bits were set");

endmodule
`default_nettype wire

//--- sim/tb_cmc_top.sv
// tb_cmc_top: self-checking bench for the clock and mode controller
// assumes the 128 kHz oscillator build so that clock periods stay short
`timescale 1ns/1ps
`default_nettype none
module tb_cmc_top;
	import cmc_pkg::*;
	localparam int HS_P = 2 * OSC_128K_HALF;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        halt, porta, int_req, wdt_ovf, wdt_en;
	logic        hs_clk, sys_clk, cpu_clk, sub_clk, lvd_off, pdf_set, to_clr, wdt_clr, sys_prev;
	cmc_mode_t   mode;
	int          error_cnt, compares, run, n;
	int          sels[5] = '{0, 1, 2, 3, 7};

	cmc_top #(.OSC_SEL(OSC_SEL_128K)) DUT (
		.SYS_CLK_I(clk), .RESETN_I(rst_n),
		.AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
		.AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
		.AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
		.AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
		.AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
		.HALT_I(halt), .PORTA_WAKE_I(porta), .INT_REQ_I(int_req), .WDT_OVF_I(wdt_ovf),
		.WDT_EN_I(wdt_en), .HS_CLK_O(hs_clk), .SYS_CLK_O(sys_clk), .CPU_CLK_O(cpu_clk),
		.SUB_CLK_O(sub_clk), .MODE_O(mode), .LVD_LCD_OFF_O(lvd_off), .PDF_SET_O(pdf_set),
		.TO_CLR_O(to_clr), .WDT_CLR_O(wdt_clr)
	);

	always #5 clk = ~clk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wrap_up;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// both bus tasks are entered right after a rising edge
	task wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic ap, wp, ah, wh, b;
		ap = 1;
		wp = 1;
		b = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (ap || wp) begin
			#1;
			ah = awready;
			wh = wready;
			@(posedge clk);
			if (ap && ah) begin
				ap = 0;
				awvalid <= 1'b0;
			end
			if (wp && wh) begin
				wp = 0;
				wvalid <= 1'b0;
			end
		end
		while (!b) begin
			#1;
			b = bvalid;
			resp = bresp;
			@(posedge clk);
		end
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
		logic ah, b;
		ah = 0;
		b = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ah) begin
			#1;
			ah = arready;
			@(posedge clk);
		end
		arvalid <= 1'b0;
		while (!b) begin
			#1;
			b = rvalid;
			v = rdata;
			resp = rresp;
			@(posedge clk);
		end
		rready <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return hs_clk;
			1: return sys_clk;
			2: return sub_clk;
			default: return cpu_clk;
		endcase
	endfunction

	task wait_rise(input int w, output int c);
		logic p, q;
		c = 0;
		#1;
		p = pick(w);
		do begin
			@(posedge clk);
			#1;
			c++;
			q = p;
			p = pick(w);
		end while (!(p && !q));
	endtask

	// third rise only, so a ratio change in flight never skews the figure
	task per_get(input int w, output int c);
		wait_rise(w, c);
		wait_rise(w, c);
		wait_rise(w, c);
		@(posedge clk);
	endtask

	task rises(input int w, input int cyc, output int cnt);
		logic p, q;
		cnt = 0;
		#1;
		p = pick(w);
		repeat (cyc) begin
			@(posedge clk);
			#1;
			q = p;
			p = pick(w);
			if (p && !q) cnt++;
		end
		@(posedge clk);
	endtask

	task do_halt(input cmc_mode_t m);
		int np, nt, nw;
		np = 0;
		nt = 0;
		nw = 0;
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		#1;
		check(32'(mode), 32'(m));
		check(32'(lvd_off), 32'(m == CMC_SLEEP));
		// the entry pulses stand in the cycle right after the halt is taken
		repeat (4) begin
			if (pdf_set === 1'b1) np++;
			if (to_clr === 1'b1) nt++;
			if (wdt_clr === 1'b1) nw++;
			@(posedge clk);
			#1;
		end
		check(32'(np * 100 + nt * 10 + nw), 32'd111);
		@(posedge clk);
	endtask

	task wake(input int src, input int lim);
		int k;
		k = 0;
		case (src)
			0: int_req <= 1'b1;
			1: wdt_ovf <= 1'b1;
			default: porta <= 1'b0;
		endcase
		do begin
			@(posedge clk);
			int_req <= 1'b0;
			wdt_ovf <= 1'b0;
			#1;
			k++;
		end while (mode !== CMC_NORMAL && k < lim);
		check(32'(mode), 32'(CMC_NORMAL));
		@(posedge clk);
		porta <= 1'b1;
	endtask

	// every system clock phase must last at least one high-speed half period
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= 1000;
			sys_prev <= 1'b0;
		end else begin
			if (sys_clk !== sys_prev) begin
				check(32'(run >= int'(OSC_128K_HALF)), 32'h1);
				run <= 1;
			end else begin
				run <= run + 1;
			end
			sys_prev <= sys_clk;
		end
	end

	initial begin
		repeat (95000) @(posedge clk);
		error_cnt++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		wrap_up;
	end

	initial begin
		{clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wstrb, wdata} = '0;
		{halt, int_req, wdt_ovf, wdt_en} = '0;
		porta = 1'b1;
		error_cnt = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(ADDR_CLK_CTRL, d, r);
		check(d, 32'(CLK_CTRL_RESET));
		wr(ADDR_CLK_CTRL, 32'h0000_00FF, r);
		check(32'(r), 32'(RESP_OKAY));
		rd(ADDR_CLK_CTRL, d, r);
		check(d, 32'h0000_00E2);
		wr(4'h8, 32'h0000_00FF, r);
		check(32'(r), 32'(RESP_DECERR));
		rd(4'h8, d, r);
		check({d[29:0], r}, 32'(RESP_DECERR));
		$display("test registers done");
		per_get(0, n);
		check(32'(n), 32'(HS_P));
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_CLK_CTRL, 32'(sels[i]) << 5, r);
			per_get(1, n);
			check(32'(n), 32'(HS_P << ((sels[i] == 7) ? 0 : sels[i])));
		end
		per_get(2, n);
		check(32'(n >= 2 * OSC_32K_HALF - 8 && n <= 2 * OSC_32K_HALF + 8), 32'h1);
		$display("test clocks done");
		wr(ADDR_CLK_CTRL, 32'h0000_0022, r);
		do_halt(CMC_IDLE);
		rises(3, 2000, n);
		check(32'(n), 32'h0);
		rises(1, 2000, n);
		check(32'(n > 0), 32'h1);
		rises(2, 3300, n);
		check(32'(n > 0), 32'h1);
		rd(ADDR_STATUS, d, r);
		check(32'(d[3:0]), {28'h000_0000, 1'b1, 1'b0, 2'(CMC_IDLE)});
		wake(0, 1);
		rd(ADDR_CLK_CTRL, d, r);
		check(d, 32'h0000_0022);
		per_get(3, n);
		check(32'(n), 32'(2 * HS_P));
		$display("test idle done");
		wdt_en <= 1'b1;
		wr(ADDR_CLK_CTRL, 32'h0000_0020, r);
		do_halt(CMC_SLEEP);
		rises(0, 2000, n);
		check(32'(n), 32'h0);
		rises(1, 2000, n);
		check(32'(n), 32'h0);
		rises(2, 3300, n);
		check(32'(n > 0), 32'h1);
		wake(1, 1);
		wdt_en <= 1'b0;
		do_halt(CMC_SLEEP);
		rises(2, 3300, n);
		check(32'(n), 32'h0);
		rd(ADDR_STATUS, d, r);
		check(32'(d[3:0]), {28'h000_0000, 1'b0, 1'b0, 2'(CMC_SLEEP)});
		wake(2, 5);
		do_halt(CMC_SLEEP);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check(32'(mode), 32'(CMC_NORMAL));
		@(posedge clk);
		rd(ADDR_CLK_CTRL, d, r);
		check(d, 32'(CLK_CTRL_RESET));
		$display("test sleep done");
		wrap_up;
	end
endmodule
`default_nettype wire
